// File: pmf_pkg.sv
// constants and types of the protection settings block
package pmf_pkg;
  localparam logic [7:0] CMD_OC_LIM = 8'h46;
  localparam logic [7:0] CMD_OC_ACT = 8'h47;
  localparam logic [7:0] CMD_OC_WARN = 8'h4A;
  localparam logic [7:0] CMD_OT_LIM = 8'h4F;
  localparam logic [7:0] CMD_OT_ACT = 8'h50;

  localparam logic [15:0] OC_LIM_RST = 16'hF822;
  localparam logic [7:0] OC_ACT_RST = 8'hA1;
  localparam logic [15:0] OC_WARN_RST = 16'hF81F;
  localparam logic [15:0] OT_LIM_RST = 16'h007D;
  localparam logic [7:0] OT_ACT_RST = 8'hF9;

  // linear11 layout: exponent 15:11, mantissa 10:0
  localparam int EXP_HI = 15;
  localparam int EXP_LO = 11;
  localparam int MANT_HI = 10;
  localparam logic [4:0] EXP_HALF = 5'h1F;
  localparam logic [4:0] EXP_UNIT = 5'h00;
  localparam logic [10:0] AMP_MAX = 11'h0FE;
  localparam logic [10:0] DEG_MAX = 11'h096;

  // response byte fields
  localparam int RSP_HI = 7;
  localparam int RSP_LO = 6;
  localparam int CNT_HI = 5;
  localparam int CNT_LO = 3;
  localparam logic [1:0] RSP_NONE = 2'h0;
  localparam logic [1:0] RSP_HICCUP = 2'h2;
  localparam logic [2:0] CYCL_NEVER = 3'h7;
  localparam logic [9:0] BASE_CYC = 10'h008;

  localparam int N_OC_CODES = 10;
  localparam int N_OT_CODES = 9;
  localparam logic [7:0] OC_CODES [N_OC_CODES] =
    '{8'hA1, 8'h00, 8'h16, 8'h22, 8'h36, 8'hC0, 8'hD6, 8'hE2, 8'hF6, 8'hF8};
  localparam logic [7:0] OT_CODES [N_OT_CODES] =
    '{8'hF9, 8'h00, 8'h16, 8'h22, 8'h36, 8'hC0, 8'hD6, 8'hE2, 8'hF6};

  localparam int HICCUP_MS = 20;
  localparam int CLK_KHZ = 50000;
  localparam int HICCUP_CYC = HICCUP_MS * CLK_KHZ;
  localparam int TMR_W = 20;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_OC_LATCH = 2'b01,
    ST_OC_WAIT = 2'b10,
    ST_OT_OFF = 2'b11
  } pmf_state_t;
endpackage : pmf_pkg

// File: pmf_chk_if.sv
// carrier between a threshold word and its range checker
interface pmf_chk_if;
  logic [15:0] word;
  logic ok;
  modport chk (input word, output ok);
  modport usr (output word, input ok);
endinterface : pmf_chk_if

// File: pmf_lin_chk.sv
// range and resolution check of one linear11 threshold word
module pmf_lin_chk #(
  parameter logic [4:0] EXP = 5'h00,
  parameter logic [10:0] MAX = 11'h000
) (
  pmf_chk_if.chk c
);
  logic [10:0] mant;

  assign mant = c.word[pmf_pkg::MANT_HI:0];

  // fixed exponent means any other exponent is a wrong resolution
  assign c.ok = (c.word[pmf_pkg::EXP_HI:pmf_pkg::EXP_LO] == EXP)
    && !mant[pmf_pkg::MANT_HI] && (mant <= MAX);
endmodule : pmf_lin_chk

// File: pmf_prot.sv
// overcurrent and overtemperature protection settings and responses
////////////////////////////////////////////////////////////////////////////////
module pmf_prot #(
  parameter int HICCUP_CYC = pmf_pkg::HICCUP_CYC
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  input wire logic en_cmd,
  input wire logic sw_cycle,
  input wire logic valley_oc,
  input wire logic [10:0] iout_meas,
  input wire logic [10:0] temp_meas,
  output logic [15:0] rd_data_r,
  output logic rd_valid_r,
  output logic cmd_err_r,
  output logic out_en_r,
  output logic oc_fault_r,
  output logic oc_warn_r,
  output logic ot_fault_r,
  output logic [15:0] oc_lim_r
);
  ////////////////////////////////////////////////////////////////////////////////
  // settings registers and write checks
  logic [7:0] oc_act_r;
  logic [15:0] oc_warn_thr_r;
  logic [15:0] ot_thr_r;
  logic [7:0] ot_act_r;
  logic amp_ok;
  logic deg_ok;
  logic oc_code_ok;
  logic ot_code_ok;
  logic mapped;
  logic wr_ok;

  pmf_chk_if amp_if ();
  pmf_chk_if deg_if ();

  assign amp_if.word = cmd_wdata;
  assign deg_if.word = cmd_wdata;
  assign amp_ok = amp_if.ok;
  assign deg_ok = deg_if.ok;

  // one checker serves both current limits: same exponent and range
  pmf_lin_chk #(
    .EXP(pmf_pkg::EXP_HALF),
    .MAX(pmf_pkg::AMP_MAX)
  ) u_amp_chk (
    .c(amp_if)
  );

  pmf_lin_chk #(
    .EXP(pmf_pkg::EXP_UNIT),
    .MAX(pmf_pkg::DEG_MAX)
  ) u_deg_chk (
    .c(deg_if)
  );

  always_comb
  begin
    oc_code_ok = 1'b0;
    ot_code_ok = 1'b0;
    for (int i = 0; i < pmf_pkg::N_OC_CODES; i++)
    begin
      if (cmd_wdata[7:0] == pmf_pkg::OC_CODES[i])
      begin
        oc_code_ok = 1'b1;
      end
    end
    for (int i = 0; i < pmf_pkg::N_OT_CODES; i++)
    begin
      if (cmd_wdata[7:0] == pmf_pkg::OT_CODES[i])
      begin
        ot_code_ok = 1'b1;
      end
    end
  end

  always_comb
  begin
    mapped = 1'b1;
    wr_ok = 1'b0;
    unique case (cmd_code)
      pmf_pkg::CMD_OC_LIM: wr_ok = amp_ok;
      pmf_pkg::CMD_OC_ACT: wr_ok = oc_code_ok;
      pmf_pkg::CMD_OC_WARN: wr_ok = amp_ok;
      pmf_pkg::CMD_OT_LIM: wr_ok = deg_ok;
      pmf_pkg::CMD_OT_ACT: wr_ok = ot_code_ok;
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      oc_lim_r <= pmf_pkg::OC_LIM_RST;
      oc_act_r <= pmf_pkg::OC_ACT_RST;
      oc_warn_thr_r <= pmf_pkg::OC_WARN_RST;
      ot_thr_r <= pmf_pkg::OT_LIM_RST;
      ot_act_r <= pmf_pkg::OT_ACT_RST;
    end
    else if (cmd_wr && wr_ok)
    begin
      // rejected words never reach a register
      unique case (cmd_code)
        pmf_pkg::CMD_OC_LIM: oc_lim_r <= cmd_wdata;
        pmf_pkg::CMD_OC_ACT: oc_act_r <= cmd_wdata[7:0];
        pmf_pkg::CMD_OC_WARN: oc_warn_thr_r <= cmd_wdata;
        pmf_pkg::CMD_OT_LIM: ot_thr_r <= cmd_wdata;
        pmf_pkg::CMD_OT_ACT: ot_act_r <= cmd_wdata[7:0];
        default: ;
      endcase
    end
  end

  // error pulse for bad writes and for any unmapped code
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cmd_err_r <= 1'b0;
    end
    else
    begin
      cmd_err_r <= (cmd_wr && !wr_ok) || (cmd_rd && !mapped);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read back
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rd_data_r <= 16'h0000;
      rd_valid_r <= 1'b0;
    end
    else
    begin
      rd_valid_r <= cmd_rd && mapped;
      if (cmd_rd)
      begin
        unique case (cmd_code)
          pmf_pkg::CMD_OC_LIM: rd_data_r <= oc_lim_r;
          pmf_pkg::CMD_OC_ACT: rd_data_r <= {8'h00, oc_act_r};
          pmf_pkg::CMD_OC_WARN: rd_data_r <= oc_warn_thr_r;
          pmf_pkg::CMD_OT_LIM: rd_data_r <= ot_thr_r;
          pmf_pkg::CMD_OT_ACT: rd_data_r <= {8'h00, ot_act_r};
          default: rd_data_r <= 16'h0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // threshold comparators
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      oc_warn_r <= 1'b0;
      ot_fault_r <= 1'b0;
    end
    else
    begin
      oc_warn_r <= $signed(iout_meas)
        >= $signed(oc_warn_thr_r[pmf_pkg::MANT_HI:0]);
      ot_fault_r <= $signed(temp_meas)
        >= $signed(ot_thr_r[pmf_pkg::MANT_HI:0]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // consecutive overcurrent counting
  pmf_pkg::pmf_state_t st_r;
  pmf_pkg::pmf_state_t st_nxt;
  logic [9:0] oc_cnt_r;
  logic [9:0] oc_lim_cyc;
  logic [2:0] oc_cycl;
  logic [1:0] oc_rsp;
  logic [1:0] ot_rsp;
  logic oc_on;
  logic ot_on;
  logic trip;
  logic [pmf_pkg::TMR_W-1:0] tmr_r;

  assign oc_rsp = oc_act_r[pmf_pkg::RSP_HI:pmf_pkg::RSP_LO];
  assign oc_cycl = oc_act_r[pmf_pkg::CNT_HI:pmf_pkg::CNT_LO];
  assign ot_rsp = ot_act_r[pmf_pkg::RSP_HI:pmf_pkg::RSP_LO];
  // supported counts are 8, 32, 128, 512: eight shifted by the field
  assign oc_lim_cyc = pmf_pkg::BASE_CYC << oc_cycl;
  assign oc_on = (oc_rsp != pmf_pkg::RSP_NONE)
    && (oc_cycl != pmf_pkg::CYCL_NEVER);
  assign ot_on = ot_rsp != pmf_pkg::RSP_NONE;
  assign trip = (st_r == pmf_pkg::ST_RUN) && oc_on && sw_cycle && valley_oc
    && ({1'b0, oc_cnt_r} + 11'h001 >= {1'b0, oc_lim_cyc});

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      oc_cnt_r <= 10'h000;
    end
    else if (st_r != pmf_pkg::ST_RUN)
    begin
      oc_cnt_r <= 10'h000;
    end
    else if (sw_cycle)
    begin
      if (!valley_oc)
      begin
        oc_cnt_r <= 10'h000;
      end
      else if (oc_cnt_r != 10'h3FF)
      begin
        oc_cnt_r <= oc_cnt_r + 10'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // shutdown, hiccup and overtemperature sequencing
  always_comb
  begin
    st_nxt = st_r;
    if (!en_cmd)
    begin
      // commanded off ends every retry and clears latched shutdown
      st_nxt = pmf_pkg::ST_RUN;
    end
    else
    begin
      unique case (st_r)
        pmf_pkg::ST_RUN:
        begin
          if (ot_on && ot_fault_r)
          begin
            st_nxt = pmf_pkg::ST_OT_OFF;
          end
          else if (trip)
          begin
            st_nxt = (oc_rsp == pmf_pkg::RSP_HICCUP) ? pmf_pkg::ST_OC_WAIT
              : pmf_pkg::ST_OC_LATCH;
          end
        end
        pmf_pkg::ST_OC_LATCH:
        begin
          st_nxt = pmf_pkg::ST_OC_LATCH;
        end
        pmf_pkg::ST_OC_WAIT:
        begin
          if (tmr_r == '0)
          begin
            st_nxt = pmf_pkg::ST_RUN;
          end
        end
        pmf_pkg::ST_OT_OFF:
        begin
          if (!ot_fault_r || !ot_on)
          begin
            st_nxt = pmf_pkg::ST_RUN;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_r <= pmf_pkg::ST_RUN;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // restart wait; a new attempt re-arms counting from zero
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tmr_r <= '0;
    end
    else if (st_r != pmf_pkg::ST_OC_WAIT && st_nxt == pmf_pkg::ST_OC_WAIT)
    begin
      tmr_r <= pmf_pkg::TMR_W'(HICCUP_CYC - 1);
    end
    else if (tmr_r != '0)
    begin
      tmr_r <= tmr_r - 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      out_en_r <= 1'b0;
      oc_fault_r <= 1'b0;
    end
    else
    begin
      out_en_r <= en_cmd && (st_nxt == pmf_pkg::ST_RUN);
      oc_fault_r <= (st_nxt == pmf_pkg::ST_OC_LATCH)
        || (st_nxt == pmf_pkg::ST_OC_WAIT);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  bad_warn_drop_a: assert property (
    cmd_wr && cmd_code == pmf_pkg::CMD_OC_WARN && !amp_ok
    |=> cmd_err_r && $stable(oc_warn_thr_r))
    else $error("bad warning threshold write not rejected");

  bad_code_drop_a: assert property (
    cmd_wr && cmd_code == pmf_pkg::CMD_OT_ACT && !ot_code_ok
    |=> cmd_err_r && $stable(ot_act_r))
    else $error("unsupported ot action accepted");

  warn_level_a: assert property (
    ##1 oc_warn_r == ($signed($past(iout_meas))
      >= $signed($past(oc_warn_thr_r[10:0]))))
    else $error("warning flag disagrees with threshold");

  ot_level_a: assert property (
    ##1 ot_fault_r == ($signed($past(temp_meas))
      >= $signed($past(ot_thr_r[10:0]))))
    else $error("ot fault flag disagrees with threshold");

  no_action_a: assert property (
    oc_rsp == pmf_pkg::RSP_NONE && ot_rsp == pmf_pkg::RSP_NONE
    && st_r == pmf_pkg::ST_RUN && en_cmd |=> out_en_r)
    else $error("output dropped with no action selected");

  never_trip_a: assert property (
    oc_cycl == pmf_pkg::CYCL_NEVER && st_r == pmf_pkg::ST_RUN
    |=> !oc_fault_r)
    else $error("overcurrent fault with count field 111");

  trip_count_a: assert property (
    $rose(oc_fault_r) |-> $past(oc_cnt_r) + 10'h001 == $past(oc_lim_cyc)
      && $past(valley_oc))
    else $error("shutdown at wrong consecutive count");

  count_clear_a: assert property (
    sw_cycle && !valley_oc |=> oc_cnt_r == 10'h000)
    else $error("clean cycle did not clear count");

  hiccup_hold_a: assert property (
    st_r == pmf_pkg::ST_OC_WAIT && tmr_r != '0 && en_cmd
    |=> st_r == pmf_pkg::ST_OC_WAIT && !out_en_r)
    else $error("hiccup restart before wait ended");

  latch_hold_a: assert property (
    st_r == pmf_pkg::ST_OC_LATCH && en_cmd |=> !out_en_r [*2])
    else $error("latched shutdown released while enabled");

  ot_off_a: assert property (
    ot_fault_r && ot_on && st_r == pmf_pkg::ST_RUN |=> !out_en_r)
    else $error("output left on during ot fault");

  ot_resume_a: assert property (
    st_r == pmf_pkg::ST_OT_OFF && !ot_fault_r && en_cmd |=> out_en_r)
    else $error("output not resumed after ot fault");
endmodule : pmf_prot

// File: pmf_stage_model.sv
// power stage model: switching cycle pulses and valley overcurrent level
module pmf_stage_model (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic run,
  input wire logic oc_on,
  output logic sw_cycle,
  output logic valley_oc
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ph_r;

  // one switching cycle every second clock
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ph_r <= 1'b0;
      sw_cycle <= 1'b0;
      valley_oc <= 1'b0;
    end
    else
    begin
      ph_r <= ~ph_r;
      sw_cycle <= run & ph_r;
      // only valid at a pulse; inverted between pulses so stale sampling shows
      valley_oc <= (run & ph_r) ? oc_on : ~oc_on;
    end
  end
endmodule : pmf_stage_model

// File: pmf_prot_tb_top.sv
// self-checking bench of the protection settings block
`define CHK(a, b) \
  begin \
    comparisons++; \
    if ((a) !== (b)) \
    begin \
      miscompares++; \
      $display("wrong value at %0t: %h vs %h", $time, (a), (b)); \
    end \
  end

module pmf_prot_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic cmd_wr = 1'b0;
  logic cmd_rd = 1'b0;
  logic [7:0] cmd_code = 8'h00;
  logic [15:0] cmd_wdata = 16'h0000;
  logic en_cmd = 1'b1;
  logic run = 1'b0;
  logic oc_on = 1'b0;
  logic [10:0] iout_meas = 11'h000;
  logic [10:0] temp_meas = 11'h000;
  logic sw_cycle, valley_oc, rd_valid_r, cmd_err_r;
  logic out_en_r, oc_fault_r, oc_warn_r, ot_fault_r;
  logic [15:0] rd_data_r, oc_lim_r;
  int miscompares = 0;
  int comparisons = 0;
  int off;
  logic [7:0] trip_code [4] = '{8'hC0, 8'hD6, 8'hE2, 8'hF6};
  int trip_n [4] = '{8, 32, 128, 512};
  // code 00 last, so the ot codes with action 00 run with no oc action either
  logic [7:0] calm_code [5] = '{8'hF8, 8'h16, 8'h22, 8'h36, 8'h00};
  logic [7:0] ot_code [9] =
    '{8'hF9, 8'hC0, 8'hD6, 8'hE2, 8'hF6, 8'h00, 8'h16, 8'h22, 8'h36};

  always #10 ref_clk = ~ref_clk;

  pmf_prot #(.HICCUP_CYC(50)) pmf_prot_inst (.ref_clk(ref_clk), .nrst(nrst),
    .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .en_cmd(en_cmd), .sw_cycle(sw_cycle), .valley_oc(valley_oc),
    .iout_meas(iout_meas), .temp_meas(temp_meas), .rd_data_r(rd_data_r),
    .rd_valid_r(rd_valid_r), .cmd_err_r(cmd_err_r), .out_en_r(out_en_r),
    .oc_fault_r(oc_fault_r), .oc_warn_r(oc_warn_r), .ot_fault_r(ot_fault_r),
    .oc_lim_r(oc_lim_r));

  pmf_stage_model pmf_stage_model_inst (.ref_clk(ref_clk), .nrst(nrst), .run(run),
    .oc_on(oc_on), .sw_cycle(sw_cycle), .valley_oc(valley_oc));

  //////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    if (miscompares == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test

  task automatic wr(input logic [7:0] code, input logic [15:0] data, input logic err);
    @(posedge ref_clk);
    cmd_wr <= 1'b1;
    cmd_code <= code;
    cmd_wdata <= data;
    @(posedge ref_clk);
    cmd_wr <= 1'b0;
    @(negedge ref_clk);
    `CHK(cmd_err_r, err)
  endtask : wr

  task automatic rd(input logic [7:0] code, input logic [15:0] exp);
    @(posedge ref_clk);
    cmd_rd <= 1'b1;
    cmd_code <= code;
    @(posedge ref_clk);
    cmd_rd <= 1'b0;
    @(negedge ref_clk);
    `CHK(rd_valid_r, 1'b1)
    `CHK(rd_data_r, exp)
  endtask : rd

  // a short broken run first, so a count that is not cleared trips early
  task automatic oc_run(input logic [7:0] code, input int n);
    int cnt;
    cnt = 0;
    wr(8'h47, {8'h00, code}, 1'b0);
    @(posedge ref_clk) oc_on <= 1'b1;
    repeat (12) @(posedge ref_clk);
    oc_on <= 1'b0;
    repeat (4) @(posedge ref_clk);
    oc_on <= 1'b1;
    repeat (3000)
    begin
      @(negedge ref_clk);
      if (out_en_r !== 1'b1)
        break;
      if (sw_cycle === 1'b1 && valley_oc === 1'b1)
        cnt++;
    end
    `CHK(cnt, n)
    `CHK(oc_fault_r, 1'b1)
  endtask : oc_run

  task automatic ot_run(input logic [7:0] code, input logic stop);
    wr(8'h50, {8'h00, code}, 1'b0);
    @(posedge ref_clk) temp_meas <= 11'h050;
    repeat (4) @(negedge ref_clk);
    `CHK(ot_fault_r, 1'b1)
    `CHK(out_en_r, ~stop)
    @(posedge ref_clk) temp_meas <= 11'h04F;
    repeat (4) @(negedge ref_clk);
    `CHK(ot_fault_r, 1'b0)
    `CHK(out_en_r, 1'b1)
  endtask : ot_run

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    run <= 1'b1;
    repeat (2) @(negedge ref_clk);
    `CHK(oc_lim_r, 16'hF822)
    rd(8'h47, 16'h00A1);
    rd(8'h4A, 16'hF81F);
    rd(8'h4F, 16'h007D);
    rd(8'h50, 16'h00F9);
    wr(8'h4A, 16'hF820, 1'b0);
    rd(8'h4A, 16'hF820);
    wr(8'h4A, 16'hF0FE, 1'b1);
    wr(8'h4A, 16'hF8FF, 1'b1);
    wr(8'h4A, 16'hFC00, 1'b1);
    rd(8'h4A, 16'hF820);
    wr(8'h4A, 16'hF8FE, 1'b0);
    rd(8'h4A, 16'hF8FE);
    wr(8'h4F, 16'h0097, 1'b1);
    wr(8'h4F, 16'hF850, 1'b1);
    wr(8'h4F, 16'h0096, 1'b0);
    rd(8'h4F, 16'h0096);
    wr(8'h50, 16'h00A1, 1'b1);
    wr(8'h47, 16'h00F9, 1'b1);
    rd(8'h50, 16'h00F9);
    wr(8'h51, 16'h0000, 1'b1);
    wr(8'h46, 16'hF830, 1'b0);
    wr(8'h46, 16'hF900, 1'b1);
    rd(8'h46, 16'hF830);
    `CHK(oc_lim_r, 16'hF830)
    wr(8'h4A, 16'hF81F, 1'b0);
    @(posedge ref_clk) iout_meas <= 11'h01F;
    repeat (3) @(negedge ref_clk);
    `CHK(oc_warn_r, 1'b1)
    @(posedge ref_clk) iout_meas <= 11'h01E;
    repeat (3) @(negedge ref_clk);
    `CHK(oc_warn_r, 1'b0)
    for (int i = 0; i < 4; i++)
    begin
      oc_run(trip_code[i], trip_n[i]);
      @(posedge ref_clk) oc_on <= 1'b0;
      repeat (60) @(negedge ref_clk);
      `CHK(out_en_r, 1'b0)
      @(posedge ref_clk) en_cmd <= 1'b0;
      repeat (3) @(posedge ref_clk);
      en_cmd <= 1'b1;
      repeat (3) @(negedge ref_clk);
      `CHK(out_en_r, 1'b1)
    end
    oc_run(8'hA1, 128);
    off = 0;
    while (out_en_r !== 1'b1 && off < 500)
    begin
      @(negedge ref_clk);
      off++;
    end
    `CHK((off > 48) && (off < 53), 1'b1)
    @(posedge ref_clk) oc_on <= 1'b0;
    repeat (400) @(negedge ref_clk);
    `CHK(out_en_r, 1'b1)
    `CHK(oc_fault_r, 1'b0)
    for (int i = 0; i < 5; i++)
    begin
      wr(8'h47, {8'h00, calm_code[i]}, 1'b0);
      @(posedge ref_clk) oc_on <= 1'b1;
      repeat (1100) @(negedge ref_clk);
      `CHK(out_en_r, 1'b1)
      `CHK(oc_fault_r, 1'b0)
      @(posedge ref_clk) oc_on <= 1'b0;
    end
    wr(8'h4F, 16'h0050, 1'b0);
    for (int i = 0; i < 9; i++)
      ot_run(ot_code[i], i < 5);
    // second reset in mid-run must bring every setting back to its default
    @(posedge ref_clk) nrst <= 1'b0;
    repeat (2) @(negedge ref_clk);
    `CHK(oc_lim_r, 16'hF822)
    `CHK(out_en_r, 1'b0)
    @(posedge ref_clk) nrst <= 1'b1;
    rd(8'h47, 16'h00A1);
    rd(8'h4A, 16'hF81F);
    rd(8'h4F, 16'h007D);
    rd(8'h50, 16'h00F9);
    stop_test();
  end

  // the whole sequence takes about 8k cycles
  initial
  begin
    #1000000;
    miscompares++;
    stop_test();
  end
endmodule : pmf_prot_tb_top
